/* inc/sadc_pkg.sv */
// Purpose: shared constants and types of the converter mode control block
// Assumes: 100 MHz system clock, byte-wide registers on a plain port
// Notes:   all offsets are byte addresses on a 20-bit address bus
package sadc_pkg;

  // register map
  localparam int unsigned ADDR_W      = 20;
  localparam logic [19:0] OFF_MODE    = 20'hF_FF30;
  localparam logic [19:0] OFF_RES     = 20'hF_0010;
  localparam logic [19:0] OFF_STAT    = 20'hF_FF3C;
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [7:0]  RES_RST     = 8'h00;

  // field positions
  localparam int unsigned MODE_START_POS   = 7;
  localparam int unsigned MODE_DIVHI_POS   = 4;
  localparam int unsigned MODE_DIVLO_POS   = 3;
  localparam int unsigned MODE_SHORT_POS   = 1;
  localparam int unsigned MODE_CMPEN_POS   = 0;
  localparam int unsigned RES_TYPE_POS     = 0;
  localparam int unsigned STAT_SETTLED_POS = 0;
  localparam int unsigned STAT_BUSY_POS    = 1;
  localparam int unsigned STAT_EARLY_POS   = 2;

  // divider codes and terminal counts (divisor minus one)
  localparam logic [1:0] DIV_BY8  = 2'h0;
  localparam logic [1:0] DIV_BY4  = 2'h1;
  localparam logic [1:0] DIV_BY2  = 2'h2;
  localparam logic [1:0] DIV_BY1  = 2'h3;
  localparam logic [2:0] DIV8_TERM = 3'h7;
  localparam logic [2:0] DIV4_TERM = 3'h3;
  localparam logic [2:0] DIV2_TERM = 3'h1;
  localparam logic [2:0] DIV1_TERM = 3'h0;

  // conversion lengths in conversion clocks
  localparam logic [4:0] TOT_10_LONG  = 5'h17;
  localparam logic [4:0] TOT_10_SHORT = 5'h11;
  localparam logic [4:0] TOT_8_LONG   = 5'h15;
  localparam logic [4:0] TOT_8_SHORT  = 5'h0F;
  localparam logic [4:0] SAMP_LONG    = 5'h09;
  localparam logic [4:0] SAMP_SHORT   = 5'h03;
  localparam int unsigned SAR_W       = 10;
  localparam logic [3:0] MSB_IDX      = 4'h9;
  localparam logic [3:0] LSB_IDX_10   = 4'h0;
  localparam logic [3:0] LSB_IDX_8    = 4'h2;

  // comparator settling time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_NS     = 100;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SETTLE_CNT    = 4'(SETTLE_CYC);

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_RESOLVE, ST_FINISH} sadc_state_e;

endpackage

/* design/sadc_clkdiv.sv */
// Purpose: conversion clock enable, system clock divided by 8, 4, 2 or 1
// Assumes: restart aligns the first conversion clock to a start
// Notes:   tick is a one-cycle pulse at the end of each conversion clock
`timescale 1ns/1ps
module sadc_clkdiv
  import sadc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [2:0] cnt_reg;
  logic [2:0] term;

  // terminal count from the divider field
  always_comb begin
    case (sel_i)
      DIV_BY8: term = DIV8_TERM;
      DIV_BY4: term = DIV4_TERM;
      DIV_BY2: term = DIV2_TERM;
      default: term = DIV1_TERM;
    endcase
  end

  // free-running count, restarted so each conversion starts on a full clock
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg >= term) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  assign tick_o = (cnt_reg >= term) && !restart_i;

endmodule

/* design/sadc_mode_control.sv */
// Purpose: mode control of a successive-approximation converter
// Assumes: synchronous comparator result on CMP_I, plain register port
// Notes:   result registers are outputs here; channel select lives elsewhere
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module sadc_mode_control
  import sadc_pkg::*;
(
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  input  wire logic              CLK_GATE_EN_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic [7:0]        WMASK_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  input  wire logic              CMP_I,
  output logic      [7:0]        RDATA_O,
  output logic                   COMP_EN_O,
  output logic                   SAMPLE_O,
  output logic      [SAR_W-1:0]  SAR_TRIAL_O,
  output logic      [SAR_W-1:0]  RESULT_O,
  output logic                   DONE_IRQ_O
);

  logic              clr;
  logic              wr_mode;
  logic              wr_res;
  logic              ce_new;
  logic              start_evt;
  logic              stop_evt;
  logic              done_evt;
  logic              conv_tick;
  logic [1:0]        div_reg;
  logic              short_reg;
  logic              ce_reg;
  logic              cs_reg;
  logic              res_reg;
  logic [3:0]        settle_reg;
  logic              early_reg;
  sadc_state_e       state_reg;
  sadc_state_e       state_next;
  logic [4:0]        tick_cnt_reg;
  logic [4:0]        tick_cnt_next;
  logic [3:0]        bit_idx_reg;
  logic [3:0]        bit_idx_next;
  logic [SAR_W-1:0]  sar_reg;
  logic [SAR_W-1:0]  sar_next;
  logic [4:0]        tot_sel;
  logic [4:0]        samp_sel;
  logic [3:0]        lsb_sel;
  logic [7:0]        mode_rd;
  logic [7:0]        stat_rd;
  logic [7:0]        rdata_reg;
  logic [SAR_W-1:0]  result_reg;
  logic              done_reg;
  logic              sample_reg;

  // gate off behaves like reset and swallows writes
  assign clr     = RESET_I || !CLK_GATE_EN_I;
  assign wr_mode = WR_I && (ADDR_I == OFF_MODE) && CLK_GATE_EN_I;
  assign wr_res  = WR_I && (ADDR_I == OFF_RES) && CLK_GATE_EN_I;

  // enable value as it stands after this write; a mask bit per data bit
  assign ce_new    = WMASK_I[MODE_CMPEN_POS] ? WDATA_I[MODE_CMPEN_POS] : ce_reg;
  // start only from standby with the comparator staying enabled
  assign start_evt = wr_mode && WMASK_I[MODE_START_POS] && WDATA_I[MODE_START_POS]
                     && !cs_reg && ce_reg && ce_new;
  // a zero on start, or dropping the enable, ends the conversion at once
  assign stop_evt  = wr_mode && ((WMASK_I[MODE_START_POS] && !WDATA_I[MODE_START_POS])
                     || (WMASK_I[MODE_CMPEN_POS] && !WDATA_I[MODE_CMPEN_POS]));

  // conversion length and sampling length from resolution and sampling option
  always_comb begin
    case ({res_reg, short_reg})
      2'b00:   tot_sel = TOT_10_LONG;
      2'b01:   tot_sel = TOT_10_SHORT;
      2'b10:   tot_sel = TOT_8_LONG;
      default: tot_sel = TOT_8_SHORT;
    endcase
    samp_sel = short_reg ? SAMP_SHORT : SAMP_LONG;
    lsb_sel  = res_reg ? LSB_IDX_8 : LSB_IDX_10;
  end

  sadc_clkdiv u_clkdiv (
    .clk_i     (CLK_SYS_I),
    .rst_i     (clr),
    .restart_i (start_evt),
    .sel_i     (div_reg),
    .tick_o    (conv_tick)
  );

  // mode fields; reserved bits are not stored and read zero
  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      div_reg   <= MODE_RST[MODE_DIVHI_POS:MODE_DIVLO_POS];
      short_reg <= MODE_RST[MODE_SHORT_POS];
      ce_reg    <= MODE_RST[MODE_CMPEN_POS];
    end else if (wr_mode) begin
      if (WMASK_I[MODE_DIVHI_POS]) begin
        div_reg[1] <= WDATA_I[MODE_DIVHI_POS];
      end
      if (WMASK_I[MODE_DIVLO_POS]) begin
        div_reg[0] <= WDATA_I[MODE_DIVLO_POS];
      end
      if (WMASK_I[MODE_SHORT_POS]) begin
        short_reg <= WDATA_I[MODE_SHORT_POS];
      end
      if (WMASK_I[MODE_CMPEN_POS]) begin
        ce_reg <= WDATA_I[MODE_CMPEN_POS];
      end
    end
  end

  // start bit: software clear and hardware end win over a set
  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      cs_reg <= MODE_RST[MODE_START_POS];
    end else if (stop_evt || done_evt) begin
      cs_reg <= 1'b0;
    end else if (start_evt) begin
      cs_reg <= 1'b1;
    end
  end

  // resolution register, only bit 0 is kept
  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      res_reg <= RES_RST[RES_TYPE_POS];
    end else if (wr_res && WMASK_I[RES_TYPE_POS]) begin
      res_reg <= WDATA_I[RES_TYPE_POS];
    end
  end

  // comparator settling count; a start before it ends marks the result suspect
  always_ff @(posedge CLK_SYS_I) begin
    if (clr || !ce_reg) begin
      settle_reg <= 4'h0;
    end else if (settle_reg != SETTLE_CNT) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      early_reg <= 1'b0;
    end else if (start_evt) begin
      early_reg <= (settle_reg != SETTLE_CNT);
    end
  end

  // conversion sequencer, advancing once per conversion clock
  always_comb begin
    state_next    = state_reg;
    tick_cnt_next = tick_cnt_reg;
    bit_idx_next  = bit_idx_reg;
    sar_next      = sar_reg;
    done_evt      = 1'b0;
    if (start_evt) begin
      state_next    = ST_SAMPLE;
      tick_cnt_next = 5'h00;
      bit_idx_next  = MSB_IDX;
      sar_next      = '0;
    end else if (stop_evt) begin
      state_next = ST_IDLE;
    end else if (conv_tick && (state_reg != ST_IDLE)) begin
      tick_cnt_next = tick_cnt_reg + 5'h01;
      case (state_reg)
        ST_SAMPLE: begin
          // sampling done; first trial is half scale
          if (tick_cnt_reg == samp_sel - 5'h01) begin
            state_next        = ST_RESOLVE;
            sar_next[MSB_IDX] = 1'b1;
          end
        end
        ST_RESOLVE: begin
          // keep or drop the trial bit, then try the next lower one
          sar_next[bit_idx_reg] = CMP_I;
          if (bit_idx_reg == lsb_sel) begin
            state_next = ST_FINISH;
          end else begin
            bit_idx_next           = bit_idx_reg - 4'h1;
            sar_next[bit_idx_next] = 1'b1;
          end
        end
        ST_FINISH: begin
          // spare clocks round the conversion up to its full length
          if (tick_cnt_reg == tot_sel - 5'h01) begin
            done_evt   = 1'b1;
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 5'h00;
      bit_idx_reg  <= MSB_IDX;
      sar_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      bit_idx_reg  <= bit_idx_next;
      sar_reg      <= sar_next;
    end
  end

  // result and done pulse in the same edge; 8-bit leaves the two lsbs zero
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I || !CLK_GATE_EN_I) begin
      result_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= done_evt;
      if (done_evt) begin
        result_reg <= sar_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (clr) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= (state_next == ST_SAMPLE);
    end
  end

  // read mux; data stands only in the cycle after the strobe
  assign mode_rd = {cs_reg, 2'b00, div_reg, 1'b0, short_reg, ce_reg};
  assign stat_rd = {5'h00, early_reg, (state_reg != ST_IDLE), (settle_reg == SETTLE_CNT)};

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      rdata_reg <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        OFF_MODE: rdata_reg <= mode_rd;
        OFF_RES:  rdata_reg <= {7'h00, res_reg};
        OFF_STAT: rdata_reg <= stat_rd;
        default:  rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA_O     = rdata_reg;
  assign COMP_EN_O   = ce_reg;
  assign SAMPLE_O    = sample_reg;
  assign SAR_TRIAL_O = sar_reg;
  assign RESULT_O    = result_reg;
  assign DONE_IRQ_O  = done_reg;

  // helper counts of conversion clocks, independent of the sequencer
  logic [4:0] h_tot;
  logic [4:0] h_samp;
  always_ff @(posedge CLK_SYS_I) begin
    if (clr || start_evt) begin
      h_tot  <= 5'h00;
      h_samp <= 5'h00;
    end else if (conv_tick && state_reg != ST_IDLE) begin
      h_tot  <= h_tot + 5'h01;
      h_samp <= h_samp + ((state_reg == ST_SAMPLE) ? 5'h01 : 5'h00);
    end
  end

  property p_reset_clear;
    @(posedge CLK_SYS_I) RESET_I |=> (mode_rd == MODE_RST) && !res_reg;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");

  property p_start_needs_ce;
    @(posedge CLK_SYS_I) disable iff (RESET_I) $rose(cs_reg) |-> $past(ce_reg) && ce_reg;
  endproperty
  a_start_needs_ce: assert property (p_start_needs_ce) else $error("start without enable");

  property p_write_zero_clears;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr_mode && WMASK_I[MODE_START_POS] && !WDATA_I[MODE_START_POS]) |=> !cs_reg && !SAMPLE_O;
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears) else $error("start not cleared");

  property p_no_prohibited;
    @(posedge CLK_SYS_I) disable iff (RESET_I) cs_reg |-> ce_reg;
  endproperty
  a_no_prohibited: assert property (p_no_prohibited) else $error("start set, enable clear");

  property p_ce_write;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      (wr_mode && WMASK_I[MODE_CMPEN_POS]) |=> COMP_EN_O == $past(WDATA_I[MODE_CMPEN_POS]);
  endproperty
  a_ce_write: assert property (p_ce_write) else $error("enable not written");

  property p_div8_spacing;
    @(posedge CLK_SYS_I) disable iff (clr)
      (conv_tick && div_reg == DIV_BY8 && state_reg == ST_RESOLVE && !WR_I)
        |=> (!conv_tick)[*7] ##1 conv_tick;
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide by 8 wrong");

  property p_conv_length;
    @(posedge CLK_SYS_I) disable iff (clr)
      done_evt |-> (h_tot + 5'h01 == tot_sel) && (h_samp == samp_sel);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_res_readback;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      (RD_I && ADDR_I == OFF_RES) |=> (RDATA_O[7:1] == 7'h00) && (RDATA_O[0] == res_reg);
  endproperty
  a_res_readback: assert property (p_res_readback) else $error("resolution readback wrong");

  property p_bit_write;
    @(posedge CLK_SYS_I) disable iff (clr)
      (wr_res && !WMASK_I[RES_TYPE_POS]) |=> $stable(res_reg);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("masked bit changed");

  property p_done_latch;
    @(posedge CLK_SYS_I) disable iff (clr)
      DONE_IRQ_O |-> (RESULT_O == SAR_TRIAL_O) && !cs_reg ##1 !DONE_IRQ_O;
  endproperty
  a_done_latch: assert property (p_done_latch) else $error("done without result");

  property p_gate_holds;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      !CLK_GATE_EN_I |=> (mode_rd == MODE_RST) && !res_reg && !SAMPLE_O;
  endproperty
  a_gate_holds: assert property (p_gate_holds) else $error("gate off not cleared");

  property p_eight_bit_lsbs;
    @(posedge CLK_SYS_I) disable iff (clr)
      (DONE_IRQ_O && res_reg) |-> RESULT_O[1:0] == 2'b00;
  endproperty
  a_eight_bit_lsbs: assert property (p_eight_bit_lsbs) else $error("8-bit lsbs set");

endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for the converter mode control block
// Assumes: register port driven by the bench itself, comparator modelled from the trial value
// Notes:   conversion length is measured from the start write to the done pulse
`timescale 1ns/1ps
module testbench
  import sadc_pkg::*;
;
  logic              clk_sys;
  logic              reset;
  logic              gate_en;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        wmask;
  logic              wr;
  logic              rd;
  logic              cmp;
  logic [7:0]        rdata;
  logic              comp_en;
  logic              sample;
  logic [SAR_W-1:0]  sar_trial;
  logic [SAR_W-1:0]  result;
  logic              done_irq;
  int                mismatches;
  int                samples_checked;
  logic [7:0]        d;
  int                cnt;
  int                scnt;
  int                dcnt;
  int                tot;
  logic [SAR_W-1:0]  vin;

  sadc_mode_control dut (
    .CLK_SYS_I     (clk_sys),
    .RESET_I       (reset),
    .CLK_GATE_EN_I (gate_en),
    .ADDR_I        (addr),
    .WDATA_I       (wdata),
    .WMASK_I       (wmask),
    .WR_I          (wr),
    .RD_I          (rd),
    .CMP_I         (cmp),
    .RDATA_O       (rdata),
    .COMP_EN_O     (comp_en),
    .SAMPLE_O      (sample),
    .SAR_TRIAL_O   (sar_trial),
    .RESULT_O      (result),
    .DONE_IRQ_O    (done_irq)
  );

  // 100 MHz system clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // comparator partner: input at or above the trial tap; registered, so one clock late
  // and exact only when conversion clocks are at least two system clocks apart
  always @(posedge clk_sys) begin
    cmp <= (vin >= sar_trial);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, taken at the second edge
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] v, input logic [7:0] m);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    wmask <= m;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [19:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // runs until the done pulse, counting cycles from the start write and sampling cycles
  task automatic run_conv();
    #1;
    cnt  = 1;
    scnt = 0;
    while (done_irq !== 1'b1 && cnt < 400) begin
      if (sample === 1'b1) scnt++;
      @(posedge clk_sys);
      #1 cnt++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under 10k cycles
  initial begin
    #200_000;
    mismatches++;
    test_done();
  end

  initial begin
    reset   = 1'b1;
    gate_en = 1'b1;
    addr    = '0;
    wdata   = 8'h00;
    wmask   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    vin     = '0;
    mismatches      = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;

    // reset values and an unmapped address
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0000);
    rd_reg(OFF_RES, d); chk(16'(d), 16'h0000);
    rd_reg(20'h0_1234, d); chk(16'(d), 16'h0000);
    $display("test reset done");

    // start request while the comparator is off must be dropped
    wr_reg(OFF_MODE, 8'h80, 8'h80);
    #1 chk(16'(sample), 16'h0000);
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0000);
    wr_reg(OFF_MODE, 8'h01, 8'hFF);
    #1 chk(16'(comp_en), 16'h0001);
    wr_reg(OFF_MODE, 8'h00, 8'h01);
    #1 chk(16'(comp_en), 16'h0000);
    wr_reg(OFF_RES, 8'hFF, 8'hFF);
    rd_reg(OFF_RES, d); chk(16'(d), 16'h0001);
    $display("test refusal done");

    // every divider, sampling length and resolution, via single-bit start writes
    for (int k = 0; k < 16; k++) begin
      logic [1:0] div;
      logic       shrt;
      logic       res;
      logic [7:0] mode;
      logic [15:0] exp_res;
      div  = k[1:0];
      shrt = k[2];
      res  = k[3];
      // undivided clock: full scale keeps the late comparator model exact
      vin  = (div == 2'h3) ? {SAR_W{1'b1}} : SAR_W'(k * 199);
      exp_res = {6'h00, (res ? (vin & 10'h3FC) : vin)};
      mode = {3'b000, div, 1'b0, shrt, 1'b1};
      tot  = res ? (shrt ? 15 : 21) : (shrt ? 17 : 23);
      wr_reg(OFF_MODE, 8'h00, 8'hFF);
      wr_reg(OFF_RES, {7'h00, res}, 8'hFF);
      wr_reg(OFF_MODE, mode, 8'hFF);
      repeat (12) @(posedge clk_sys);
      wr_reg(OFF_MODE, 8'h80, 8'h80);
      run_conv();
      chk(16'(cnt), 16'(tot * (8 >> div) + 1));
      chk(16'(scnt), 16'((shrt ? 3 : 9) * (8 >> div)));
      chk({6'h00, result}, exp_res);
      chk({6'h00, sar_trial}, exp_res);
      @(posedge clk_sys);
      #1 chk(16'(done_irq), 16'h0000);
      rd_reg(OFF_MODE, d); chk(16'(d), 16'(mode));
    end
    $display("test conversion table done");

    // a stop write aborts without a done pulse
    wr_reg(OFF_MODE, 8'h00, 8'hFF);
    wr_reg(OFF_RES, 8'h00, 8'hFF);
    wr_reg(OFF_MODE, 8'h19, 8'hFF);
    repeat (12) @(posedge clk_sys);
    wr_reg(OFF_MODE, 8'h80, 8'h80);
    repeat (20) @(posedge clk_sys);
    wr_reg(OFF_MODE, 8'h00, 8'h80);
    dcnt = 0;
    repeat (200) begin
      @(posedge clk_sys);
      #1 if (done_irq === 1'b1) dcnt++;
    end
    chk(16'(dcnt), 16'h0000);
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0019);
    // disabling the comparator mid-run leaves no start-without-enable state
    wr_reg(OFF_MODE, 8'h80, 8'h80);
    repeat (10) @(posedge clk_sys);
    rd_reg(OFF_STAT, d); chk(16'(d), 16'h0003);
    wr_reg(OFF_MODE, 8'h00, 8'h01);
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0018);
    chk(16'(comp_en), 16'h0000);
    // a start right after enabling is taken but flagged as unsettled
    wr_reg(OFF_MODE, 8'h01, 8'h01);
    wr_reg(OFF_MODE, 8'h80, 8'h80);
    rd_reg(OFF_STAT, d); chk(16'(d), 16'h0006);
    $display("test abort done");

    // clock gate off clears registers and ignores writes
    wr_reg(OFF_MODE, 8'h01, 8'hFF);
    wr_reg(OFF_RES, 8'h01, 8'hFF);
    @(posedge clk_sys);
    gate_en <= 1'b0;
    @(posedge clk_sys);
    #1 chk(16'(comp_en), 16'h0000);
    wr_reg(OFF_RES, 8'h01, 8'hFF);
    wr_reg(OFF_MODE, 8'h01, 8'hFF);
    @(posedge clk_sys);
    gate_en <= 1'b1;
    rd_reg(OFF_RES, d); chk(16'(d), 16'h0000);
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0000);
    $display("test clock gate done");

    // a second reset, with no conversion running, clears both registers again
    wr_reg(OFF_MODE, 8'h01, 8'hFF);
    wr_reg(OFF_RES, 8'h01, 8'hFF);
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    rd_reg(OFF_MODE, d); chk(16'(d), 16'h0000);
    rd_reg(OFF_RES, d); chk(16'(d), 16'h0000);
    $display("test second reset done");
    test_done();
  end
endmodule
